// File: cdt_pkg.sv
// Constants and types shared by the transmit C-bit frame generator and error inserter
package cdt_pkg;
	// Frame geometry: 85-bit blocks, 8 blocks per subframe, 7 subframes
	localparam logic [6:0] BLK_LAST_BIT = 7'h54;
	localparam logic [2:0] SF_LAST_BLK = 3'h7;
	localparam logic [2:0] MF_LAST_SF = 3'h6;
	localparam logic [2:0] SF_X2 = 3'h1;
	localparam logic [2:0] SF_P1 = 3'h2;
	localparam logic [2:0] SF_P2 = 3'h3;
	localparam logic [2:0] SF_M1 = 3'h4;
	localparam logic [2:0] SF_FEAC = 3'h0;
	localparam logic [2:0] SF_CPAR = 3'h2;
	localparam logic [2:0] SF_FEBE = 3'h3;
	localparam logic [2:0] SF_PMDL = 3'h4;
	localparam logic [1:0] C_FIRST = 2'h0;
	localparam logic [1:0] C_LAST = 2'h2;
	localparam logic [1:0] F_LAST = 2'h3;
	localparam logic [3:0] F_PATTERN = 4'h9;
	localparam logic [2:0] M_PATTERN = 3'h2;
	// APB register map
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] ERRCFG_OFF = 8'h04;
	localparam logic [7:0] ERRREQ_OFF = 8'h08;
	localparam logic [7:0] STATUS_OFF = 8'h0C;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam logic [31:0] CTRL_MASK = 32'h0000_03FF;
	localparam logic [31:0] ERRCFG_RST = 32'h0000_0000;
	localparam logic [31:0] ERRCFG_MASK = 32'h0000_07FF;
	localparam int CTRL_FG_BIT = 0;
	localparam int CTRL_PG_BIT = 1;
	localparam int CTRL_RDI_LSB = 2;
	localparam int CTRL_ALM_LSB = 4;
	localparam int CTRL_FEBE_SRC_BIT = 8;
	localparam int CTRL_FEBE_VAL_BIT = 9;
	localparam int ERRCFG_MODE_LSB = 0;
	localparam int ERRCFG_EN_LSB = 2;
	localparam int ERRCFG_CONT_LSB = 6;
	localparam int ERRCFG_SRC_BIT = 10;
	localparam int ERRREQ_BIT = 0;
	// Error type index
	localparam int NUM_ERR = 4;
	localparam int ERR_FRM = 0;
	localparam int ERR_P = 1;
	localparam int ERR_C = 2;
	localparam int ERR_FEBE = 3;

	typedef enum logic [1:0] {RDI_AUTO = 2'h0, RDI_ONE = 2'h1, RDI_ZERO = 2'h2} cdt_rdi_type;
	typedef enum logic [1:0] {FE_FBIT = 2'h0, FE_MBIT = 2'h1, FE_SEF = 2'h2, FE_OOMF = 2'h3}
		cdt_frm_mode_type;
	typedef enum logic [2:0] {FRM_IDLE = 3'h1, FRM_SEF = 3'h2, FRM_OOMF = 3'h4} cdt_frm_state_type;

	typedef struct packed {
		logic valid;
		logic sof;
		logic data;
	} cdt_bit_type;

	typedef struct packed {
		logic los;
		logic sef;
		logic lof;
		logic ais;
	} cdt_alarm_type;
endpackage : cdt_pkg

// File: cdt_sync3.sv
// Three-stage pin synchroniser whose level changes once the last two stages agree
module cdt_sync3 (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Pin and clean level
	input wire logic pin_i,
	output logic level_o
);
	logic [2:0] stage_q;
	logic level_q;
	logic level_d;

	always_comb begin
		level_d = level_q;
		if (stage_q[1] == stage_q[2]) begin
			level_d = stage_q[2];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			stage_q <= 3'h0;
			level_q <= 1'b0;
		end else begin
			stage_q <= {stage_q[1:0], pin_i};
			level_q <= level_d;
		end
	end

	assign level_o = level_q;
endmodule : cdt_sync3

// File: cdt_err_req.sv
// One error type's request holder and opportunity gate
module cdt_err_req (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic req_i,
	input wire logic en_i,
	input wire logic cont_i,
	input wire logic opp_i,
	// Result
	output logic fire_o,
	output logic pending_o
);
	logic pending_q;
	logic pending_d;
	logic fire;

	// Continuous mode fires at every opportunity, single mode only on a held request
	assign fire = opp_i & en_i & (cont_i | pending_q);

	always_comb begin
		// A request landing on the consuming cycle survives: set beats clear
		pending_d = en_i & ((pending_q & ~fire) | req_i);
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pending_q <= 1'b0;
		end else begin
			pending_q <= pending_d;
		end
	end

	assign fire_o = fire;
	assign pending_o = pending_q;
endmodule : cdt_err_req

// File: cdt_frame_gen.sv
// Transmit C-bit frame generator with error insertion and APB control
module cdt_frame_gen
	import cdt_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// APB register slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Incoming payload stream, one bit per valid
	input wire cdt_bit_type tx_in_i,
	// Receive-side conditions
	input wire cdt_alarm_type alarms_i,
	input wire logic cpar_err_i,
	// FEAC and data link sources
	input wire logic feac_bit_i,
	output logic feac_take_o,
	input wire logic pmdl_bit_i,
	output logic pmdl_take_o,
	// Manual error request pin
	input wire logic manual_error_request_pin_i,
	// Stream to overhead insertion
	output cdt_bit_type tx_out_o
);
	// Register state
	logic [31:0] ctrl_q;
	logic [31:0] ctrl_d;
	logic [31:0] errcfg_q;
	logic [31:0] errcfg_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic sw_req;
	logic mapped;
	logic [31:0] status_w;

	// Configuration fields
	logic fg_en;
	logic pg_en;
	cdt_rdi_type rdi_src;
	logic [3:0] alm_en;
	logic febe_src;
	logic febe_val;
	cdt_frm_mode_type frm_mode;
	logic [NUM_ERR-1:0] err_en;
	logic [NUM_ERR-1:0] err_cont;
	logic req_src;

	// Position state
	logic [6:0] bit_q;
	logic [6:0] bit_d;
	logic [2:0] blk_q;
	logic [2:0] blk_d;
	logic [2:0] sf_q;
	logic [2:0] sf_d;
	logic [6:0] pos_bit;
	logic [2:0] pos_blk;
	logic [2:0] pos_sf;
	logic is_oh;
	logic is_x;
	logic is_p;
	logic is_m;
	logic is_f;
	logic is_c;
	logic [1:0] f_idx;
	logic [1:0] c_idx;
	logic [1:0] m_idx;
	logic last_bit;

	// Parity and FEBE history
	logic par_acc_q;
	logic par_acc_d;
	logic par_q;
	logic par_d;
	logic cpe_seen_q;
	logic cpe_seen_d;
	logic febe_auto_q;
	logic febe_auto_d;

	// Generation and error insertion
	logic rdi_bit;
	logic febe_bit;
	logic gen_bit;
	logic inv;
	logic force0;
	logic req;
	logic pin_lvl;
	logic pin_prev_q;
	logic pin_rise;
	logic [NUM_ERR-1:0] opp;
	logic [NUM_ERR-1:0] fire;
	logic [NUM_ERR-1:0] pend;
	cdt_frm_state_type frm_q;
	cdt_frm_state_type frm_d;
	logic [2:0] hold_q;
	logic [2:0] hold_d;
	cdt_bit_type out_q;
	cdt_bit_type out_d;

	assign fg_en = ctrl_q[CTRL_FG_BIT];
	assign pg_en = ctrl_q[CTRL_PG_BIT];
	assign rdi_src = cdt_rdi_type'(ctrl_q[CTRL_RDI_LSB +: 2]);
	assign alm_en = ctrl_q[CTRL_ALM_LSB +: 4];
	assign febe_src = ctrl_q[CTRL_FEBE_SRC_BIT];
	assign febe_val = ctrl_q[CTRL_FEBE_VAL_BIT];
	assign frm_mode = cdt_frm_mode_type'(errcfg_q[ERRCFG_MODE_LSB +: 2]);
	assign err_en = errcfg_q[ERRCFG_EN_LSB +: NUM_ERR];
	assign err_cont = errcfg_q[ERRCFG_CONT_LSB +: NUM_ERR];
	assign req_src = errcfg_q[ERRCFG_SRC_BIT];

	assign status_w = {18'h0, frm_q, pend, pin_lvl, rdi_bit, febe_auto_q, par_q, sf_q};
	assign mapped = (paddr_i == CTRL_OFF) | (paddr_i == ERRCFG_OFF) |
		(paddr_i == ERRREQ_OFF) | (paddr_i == STATUS_OFF);

	// Read data is captured in the setup cycle so the access phase needs no wait state
	always_comb begin
		ctrl_d = ctrl_q;
		errcfg_d = errcfg_q;
		prdata_d = prdata_q;
		sw_req = 1'b0;
		if (psel_i & ~penable_i) begin
			case (paddr_i)
				CTRL_OFF: prdata_d = ctrl_q;
				ERRCFG_OFF: prdata_d = errcfg_q;
				ERRREQ_OFF: prdata_d = {28'h0, pend};
				STATUS_OFF: prdata_d = status_w;
				default: prdata_d = 32'h0000_0000;
			endcase
		end
		if (psel_i & penable_i & pwrite_i) begin
			case (paddr_i)
				CTRL_OFF: ctrl_d = pwdata_i & CTRL_MASK;
				ERRCFG_OFF: errcfg_d = pwdata_i & ERRCFG_MASK;
				ERRREQ_OFF: sw_req = pwdata_i[ERRREQ_BIT];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_q <= CTRL_RST;
			errcfg_q <= ERRCFG_RST;
			prdata_q <= 32'h0000_0000;
		end else begin
			ctrl_q <= ctrl_d;
			errcfg_q <= errcfg_d;
			prdata_q <= prdata_d;
		end
	end

	assign prdata_o = prdata_q;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~mapped;

	// A start-of-frame marker realigns the counters onto this very bit
	assign pos_bit = tx_in_i.sof ? 7'h00 : bit_q;
	assign pos_blk = tx_in_i.sof ? 3'h0 : blk_q;
	assign pos_sf = tx_in_i.sof ? 3'h0 : sf_q;

	// Slot decode ignores any payload marking from upstream
	assign is_oh = (pos_bit == 7'h00);
	assign is_x = is_oh & (pos_blk == 3'h0) & (pos_sf <= SF_X2);
	assign is_p = is_oh & (pos_blk == 3'h0) & ((pos_sf == SF_P1) | (pos_sf == SF_P2));
	assign is_m = is_oh & (pos_blk == 3'h0) & (pos_sf >= SF_M1);
	assign is_f = is_oh & pos_blk[0];
	assign is_c = is_oh & (pos_blk != 3'h0) & ~pos_blk[0];
	assign f_idx = pos_blk[2:1];
	assign c_idx = pos_blk[2:1] - 2'h1;
	assign m_idx = 2'(pos_sf - SF_M1);
	assign last_bit = (pos_bit == BLK_LAST_BIT) & (pos_blk == SF_LAST_BLK) &
		(pos_sf == MF_LAST_SF);

	assign rdi_bit = (rdi_src == RDI_AUTO) ? ~|(alm_en & alarms_i) : (rdi_src == RDI_ONE);
	assign febe_bit = febe_src ? febe_val : febe_auto_q;

	// Overhead overwrite; with framing off only the P-bits may still be replaced
	always_comb begin
		gen_bit = tx_in_i.data;
		if (fg_en) begin
			if (is_x) begin
				gen_bit = rdi_bit;
			end
			if (is_m) begin
				gen_bit = M_PATTERN[2'h2 - m_idx];
			end
			if (is_f) begin
				gen_bit = F_PATTERN[F_LAST - f_idx];
			end
			if (is_c) begin
				case (pos_sf)
					SF_FEAC: gen_bit = (c_idx == C_LAST) ? feac_bit_i : 1'b1;
					SF_CPAR: gen_bit = par_q;
					SF_FEBE: gen_bit = febe_bit;
					SF_PMDL: gen_bit = pmdl_bit_i;
					default: gen_bit = 1'b1;
				endcase
			end
		end
		if (is_p & (fg_en | pg_en)) begin
			gen_bit = par_q;
		end
	end

	assign feac_take_o = tx_in_i.valid & fg_en & is_c & (pos_sf == SF_FEAC) & (c_idx == C_LAST);
	assign pmdl_take_o = tx_in_i.valid & fg_en & is_c & (pos_sf == SF_PMDL);

	// Position counters and parity history
	always_comb begin
		bit_d = bit_q;
		blk_d = blk_q;
		sf_d = sf_q;
		par_acc_d = par_acc_q;
		par_d = par_q;
		cpe_seen_d = cpe_seen_q | cpar_err_i;
		febe_auto_d = febe_auto_q;
		if (tx_in_i.valid) begin
			bit_d = pos_bit + 7'h01;
			blk_d = pos_blk;
			sf_d = pos_sf;
			par_acc_d = (tx_in_i.sof ? 1'b0 : par_acc_q) ^ (~is_oh & gen_bit);
			if (pos_bit == BLK_LAST_BIT) begin
				bit_d = 7'h00;
				blk_d = pos_blk + 3'h1;
				if (pos_blk == SF_LAST_BLK) begin
					sf_d = (pos_sf == MF_LAST_SF) ? 3'h0 : pos_sf + 3'h1;
				end
			end
			if (last_bit) begin
				// An error flagged on the closing bit still counts for the closing frame
				par_d = par_acc_d;
				par_acc_d = 1'b0;
				febe_auto_d = ~cpe_seen_d;
				cpe_seen_d = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bit_q <= 7'h00;
			blk_q <= 3'h0;
			sf_q <= 3'h0;
			par_acc_q <= 1'b0;
			par_q <= 1'b0;
			cpe_seen_q <= 1'b0;
			febe_auto_q <= 1'b1;
		end else begin
			bit_q <= bit_d;
			blk_q <= blk_d;
			sf_q <= sf_d;
			par_acc_q <= par_acc_d;
			par_q <= par_d;
			cpe_seen_q <= cpe_seen_d;
			febe_auto_q <= febe_auto_d;
		end
	end

	cdt_sync3 u_pin_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(manual_error_request_pin_i),
		.level_o(pin_lvl)
	);

	assign pin_rise = pin_lvl & ~pin_prev_q;
	assign req = req_src ? pin_rise : sw_req;

	// Opportunities; a running SEF or OOMF sequence blocks a fresh framing error
	always_comb begin
		opp = '0;
		if (tx_in_i.valid) begin
			if ((frm_mode == FE_FBIT) | (frm_mode == FE_SEF)) begin
				opp[ERR_FRM] = is_f & (f_idx == 2'h0) & (frm_q == FRM_IDLE);
			end else begin
				opp[ERR_FRM] = is_m & (m_idx == 2'h0) & (frm_q == FRM_IDLE);
			end
			opp[ERR_P] = is_p & (pos_sf == SF_P1);
			opp[ERR_C] = is_c & (pos_sf == SF_CPAR) & (c_idx == C_FIRST);
			opp[ERR_FEBE] = is_c & (pos_sf == SF_FEBE) & (c_idx == C_FIRST);
		end
	end

	for (genvar i = 0; i < NUM_ERR; i++) begin : g_req
		cdt_err_req u_req (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.req_i(req),
			.en_i(err_en[i]),
			.cont_i(err_cont[i]),
			.opp_i(opp[i]),
			.fire_o(fire[i]),
			.pending_o(pend[i])
		);
	end

	// Error insertion: multi-bit errors carry on from the firing slot
	always_comb begin
		frm_d = frm_q;
		hold_d = hold_q;
		inv = 1'b0;
		force0 = 1'b0;
		if (tx_in_i.valid) begin
			case (frm_q)
				FRM_IDLE: begin
					if (fire[ERR_FRM]) begin
						inv = 1'b1;
						if (frm_mode == FE_SEF) begin
							frm_d = FRM_SEF;
						end else if (frm_mode == FE_OOMF) begin
							frm_d = FRM_OOMF;
						end
					end
				end
				FRM_SEF: begin
					if (is_f) begin
						inv = 1'b1;
						if (f_idx == F_LAST) begin
							frm_d = FRM_IDLE;
						end
					end
				end
				FRM_OOMF: begin
					if (is_m & (m_idx == 2'h0)) begin
						inv = 1'b1;
						frm_d = FRM_IDLE;
					end
				end
				default: frm_d = FRM_IDLE;
			endcase
			if (fire[ERR_P] | (hold_q[0] & is_p)) begin
				inv = 1'b1;
				hold_d[0] = fire[ERR_P];
			end
			if (fire[ERR_C] | (hold_q[1] & is_c & (pos_sf == SF_CPAR))) begin
				inv = 1'b1;
				hold_d[1] = (c_idx != C_LAST);
			end
			if (fire[ERR_FEBE] | (hold_q[2] & is_c & (pos_sf == SF_FEBE))) begin
				force0 = 1'b1;
				hold_d[2] = (c_idx != C_LAST);
			end
		end
		out_d.valid = tx_in_i.valid;
		out_d.sof = tx_in_i.valid & tx_in_i.sof;
		out_d.data = tx_in_i.valid & ~force0 & (gen_bit ^ inv);
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			frm_q <= FRM_IDLE;
			hold_q <= 3'h0;
			pin_prev_q <= 1'b0;
			out_q <= '0;
		end else begin
			frm_q <= frm_d;
			hold_q <= hold_d;
			pin_prev_q <= pin_lvl;
			out_q <= out_d;
		end
	end

	assign tx_out_o = out_q;
endmodule : cdt_frame_gen

// File: cdt_frame_gen_checker.sv
// Port-level checker for the frame generator, bound to its top module
module cdt_frame_gen_checker
	import cdt_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Stream in and out
	input wire cdt_bit_type tx_in_i,
	input wire cdt_bit_type tx_out_o,
	// Overhead source strobes
	input wire logic feac_take_o,
	input wire logic pmdl_take_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [12:0] pos_q, pos_d, cur;
	// Slot of the input bit, resynchronised by the frame start marker
	always_comb begin
		cur = (tx_in_i.valid && tx_in_i.sof) ? 13'h0 : pos_q;
		pos_d = pos_q;
		if (tx_in_i.valid)
			pos_d = (cur == 13'h1297) ? 13'h0 : cur + 13'h1;
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			pos_q <= 13'h0;
		else
			pos_q <= pos_d;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_feac_slot;
		feac_take_o |-> tx_in_i.valid && cur == 13'h1FE;
	endproperty
	a_feac_slot: assert property (p_feac_slot) else $error("feac take off its slot");
	property p_feac_once;
		feac_take_o |=> !feac_take_o;
	endproperty
	a_feac_once: assert property (p_feac_once) else $error("feac take too long");
	property p_pmdl_slot;
		pmdl_take_o |-> tx_in_i.valid && cur inside {13'hB4A, 13'hBF4, 13'hC9E};
	endproperty
	a_pmdl_slot: assert property (p_pmdl_slot) else $error("link take off its slot");
	property p_pmdl_gap;
		pmdl_take_o |=> !pmdl_take_o [*8];
	endproperty
	a_pmdl_gap: assert property (p_pmdl_gap) else $error("link takes too close");
	property p_valid;
		tx_in_i.valid |=> tx_out_o.valid;
	endproperty
	a_valid: assert property (p_valid) else $error("output bit missing");
	property p_idle;
		!tx_in_i.valid |-> !feac_take_o && !pmdl_take_o ##1 !tx_out_o.valid;
	endproperty
	a_idle: assert property (p_idle) else $error("activity without input bit");
	property p_payload;
		tx_in_i.valid && cur % 13'h55 != 13'h0 |=> tx_out_o.data == $past(tx_in_i.data);
	endproperty
	a_payload: assert property (p_payload) else $error("payload bit altered");
	property p_sof;
		tx_in_i.valid && tx_in_i.sof |=> tx_out_o.valid && tx_out_o.sof;
	endproperty
	a_sof: assert property (p_sof) else $error("frame start not forwarded");
endmodule : cdt_frame_gen_checker

bind cdt_frame_gen cdt_frame_gen_checker u_checker (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.tx_in_i(tx_in_i),
	.tx_out_o(tx_out_o),
	.feac_take_o(feac_take_o),
	.pmdl_take_o(pmdl_take_o)
);

// File: cdt_payload_src.sv
// Payload source with FEAC and data link feeders for the frame generator
module cdt_payload_src
	import cdt_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Stream and overhead feeders
	output cdt_bit_type tx_o,
	input wire logic feac_take_i,
	output logic feac_bit_o,
	input wire logic pmdl_take_i,
	output logic pmdl_bit_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic run_q;
	logic [12:0] pos_q, pos_d;
	logic [14:0] lfsr_q, lfsr_d;
	logic [7:0] feac_q, feac_d;
	logic [2:0] pmdl_q, pmdl_d;
	always_comb begin
		pos_d = (pos_q == 13'h1297) ? 13'h0 : pos_q + 13'h1;
		lfsr_d = {lfsr_q[13:0], lfsr_q[14] ^ lfsr_q[13]};
		// A new bit shows only after the edge that consumed the last one
		feac_d = feac_take_i ? {feac_q[6:0], feac_q[7]} : feac_q;
		pmdl_d = pmdl_take_i ? pmdl_q + 3'h1 : pmdl_q;
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			run_q <= 1'b0;
			pos_q <= 13'h0;
			lfsr_q <= 15'h4A3D;
			feac_q <= 8'hB4;
			pmdl_q <= 3'h0;
		end else begin
			run_q <= 1'b1;
			pos_q <= run_q ? pos_d : pos_q;
			lfsr_q <= run_q ? lfsr_d : lfsr_q;
			feac_q <= feac_d;
			pmdl_q <= pmdl_d;
		end
	end
	assign tx_o = '{valid: run_q, sof: run_q && pos_q == 13'h0, data: lfsr_q[0]};
	assign feac_bit_o = feac_q[7];
	assign pmdl_bit_o = pmdl_q[1] ^ pmdl_q[0];
endmodule : cdt_payload_src

// File: cdt_frame_gen_tb.sv
// Self-checking bench for the transmit C-bit frame generator
module cdt_frame_gen_tb
	import cdt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
	logic pready_o, pslverr_o, feac_bit_i, feac_take_o, pmdl_bit_i, pmdl_take_o, er;
	logic cpar_err_i = 1'b0, pin_i = 1'b0, par = 1'b0, prev_par = 1'b0;
	logic exp_x, exp_fb, pass, fk_q, ft_q, pk_q, pt_q;
	cdt_alarm_type alarms_i = 4'h1;
	cdt_bit_type tx_in_i, tx_out_o, in_q;
	int err_total = 0, comparisons = 0, frames = 0, pos = 0;
	int cnt [8];
	logic [31:0] cfg [5] = '{32'h185, 32'h81, 32'h309, 32'h2, CTRL_RST};
	logic [3:0] alm [5] = '{4'h8, 4'h8, 4'h8, 4'h8, 4'h0};
	logic [1:0] xf [5] = '{2'h2, 2'h0, 2'h1, 2'h0, 2'h3};
	logic [31:0] ecfg [5] = '{32'h3C, 32'h405, 32'h6, 32'h7, 32'h3FC};
	int ecnt [5][5] = '{'{0, 1, 2, 3, 3}, '{1, 0, 0, 0, 0}, '{0, 4, 0, 0, 0},
		'{2, 0, 0, 0, 0}, '{0, 14, 4, 6, 6}};
	always #12.5 clk_i = ~clk_i;
	cdt_payload_src u_src (.clk_i(clk_i), .rst_i(rst_i), .tx_o(tx_in_i),
		.feac_take_i(feac_take_o), .feac_bit_o(feac_bit_i),
		.pmdl_take_i(pmdl_take_o), .pmdl_bit_o(pmdl_bit_i));
	cdt_frame_gen DUT (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .tx_in_i(tx_in_i), .alarms_i(alarms_i),
		.cpar_err_i(cpar_err_i), .feac_bit_i(feac_bit_i), .feac_take_o(feac_take_o),
		.pmdl_bit_i(pmdl_bit_i), .pmdl_take_o(pmdl_take_o),
		.manual_error_request_pin_i(pin_i), .tx_out_o(tx_out_o));
	// Slot-wise tally of output bits that differ from the ideal frame
	task automatic mon(input int b, input int k, input int s);
		logic e;
		int c;
		e = in_q.data;
		c = 0;
		if (b != 0) begin
			par = par ^ tx_out_o.data;
		end else if (k == 0) begin
			c = s < 2 ? 1 : s < 4 ? 2 : 3;
			e = s < 2 ? exp_x : s < 4 ? prev_par : M_PATTERN[s - 4];
		end else if (k % 2 == 1) begin
			c = 4;
			e = F_PATTERN[k / 2];
		end else begin
			c = s == 2 ? 6 : s == 3 ? 7 : 5;
			e = s == 2 ? prev_par : s == 3 ? exp_fb : s == 0 && k == 6 ? fk_q : s == 4 ? pk_q : 1'b1;
			if (!pass && (ft_q !== (s == 0 && k == 6) || pt_q !== (s == 4)))
				cnt[5]++;
		end
		if (pass && c != 2)
			e = in_q.data;
		if (tx_out_o.data !== e)
			cnt[c]++;
		if (pos == 4759) begin
			frames++;
			prev_par = par;
			par = 1'b0;
		end
	endtask
	always @(posedge clk_i) begin
		if (tx_out_o.valid === 1'b1) begin
			pos = tx_out_o.sof ? 0 : pos;
			mon(pos % 85, pos / 85 % 8, pos / 680);
			pos = (pos == 4759) ? 0 : pos + 1;
		end
		in_q <= tx_in_i;
		fk_q <= feac_bit_i;
		ft_q <= feac_take_o;
		pk_q <= pmdl_bit_i;
		pt_q <= pmdl_take_o;
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// Tallies are cleared off the edge so the monitor never races the bench
	task automatic arm(input logic x, input logic f, input logic p);
		@(negedge clk_i);
		exp_x = x;
		exp_fb = f;
		pass = p;
		cnt = '{default: 0};
	endtask : arm
	task automatic frames_wait(input int n);
		int t;
		t = frames + n;
		// Wakes right after the monitor closes a frame, so no edge is lost to a race
		wait (frames >= t);
	endtask : frames_wait
	task automatic counts(input int m, input int f, input int p, input int c, input int b);
		chk(cnt[0] + cnt[1] + cnt[5], 0);
		chk(cnt[3], m);
		chk(cnt[4], f);
		chk(cnt[2], p);
		chk(cnt[6], c);
		chk(cnt[7], b);
	endtask : counts
	task automatic give_verdict();
		if (err_total == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (120000) @(posedge clk_i);
		err_total++;
		give_verdict();
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		arm(1'b1, 1'b1, 1'b0);
		apb(1'b0, CTRL_OFF, 32'h0);
		chk(rd, CTRL_RST);
		apb(1'b0, ERRCFG_OFF, 32'h0);
		chk(rd, ERRCFG_RST);
		apb(1'b0, 8'h10, 32'h0);
		chk({rd[30:0], er}, 32'h1);
		frames_wait(1);
		counts(0, 0, 0, 0, 0);
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, CTRL_OFF, cfg[i]);
			alarms_i <= alm[i];
			cpar_err_i <= (i == 1);
			@(posedge clk_i);
			cpar_err_i <= 1'b0;
			frames_wait(1);
			arm(xf[i][1], xf[i][0], i == 3);
			frames_wait(1);
			counts(0, 0, 0, 0, 0);
		end
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, ERRCFG_OFF, ecfg[i]);
			arm(1'b1, 1'b1, 1'b0);
			@(posedge clk_i);
			pin_i <= (i == 1);
			if (i != 1) begin
				apb(1'b1, ERRREQ_OFF, 32'h1);
				apb(1'b0, ERRREQ_OFF, 32'h0);
				chk(rd, {28'h0, ecfg[i][5:2]});
			end
			repeat (4) @(posedge clk_i);
			pin_i <= 1'b0;
			frames_wait(2);
			counts(ecnt[i][0], ecnt[i][1], ecnt[i][2], ecnt[i][3], ecnt[i][4]);
		end
		give_verdict();
	end
endmodule : cdt_frame_gen_tb
